/* File: core/cot_pkg.sv */
package cot_pkg;

	// Command codes seen on the command port; CMD_OV_RESP is a byte access, the rest are words
	localparam logic [7:0] CMD_GAIN = 8'h38;
	localparam logic [7:0] CMD_OFFSET = 8'h39;
	localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
	localparam logic [7:0] CMD_OV_RESP = 8'h41;

	// Phase pointer value that addresses the whole stack
	localparam logic [7:0] PHASE_ALL = 8'hFF;
	localparam int PHASES_MAX = 4;

	// Linear word layout and reset values
	localparam int EXP_MSB = 15;
	localparam int EXP_LSB = 11;
	localparam logic [4:0] GAIN_EXP_RST = 5'h19;
	localparam logic [4:0] OFS_EXP_RST = 5'h1C;
	localparam logic [10:0] GAIN_MAN_UNITY = 11'h080;
	localparam logic [15:0] GAIN_RST = {GAIN_EXP_RST, GAIN_MAN_UNITY};
	localparam logic [15:0] OFS_RST = {OFS_EXP_RST, 11'h000};
	localparam logic [15:0] OV_LIMIT_RST = 16'h0000;
	localparam logic [7:0] OV_RESP_RST = 8'h00;

	// Fixed point scales
	localparam int GAIN_FRAC = 10;
	localparam int OFS_FRAC = 4;
	localparam int GAIN_NVM_FRAC = 6;
	localparam int GAIN_NVM_SHIFT = 1;
	localparam logic signed [31:0] GAIN_NVM_MAX = 32'sh7F;
	localparam logic signed [31:0] GAIN_LIMIT_Q = 32'sh800;
	localparam logic signed [31:0] OFS_MIN_Q = -32'sh200;
	localparam logic signed [31:0] OFS_MAX_Q = 32'sh1FF;
	localparam logic signed [31:0] FIX_SAT = 32'sh40000000;

	// Overvoltage steps in tenths of a percent of the target
	localparam logic [11:0] OV_RUN_BASE_X10 = 12'h41A;
	localparam logic [11:0] OV_RUN_STEP_X10 = 12'h019;
	localparam int OV_RUN_STEPS = 15;
	localparam logic [11:0] OV_OFF_BASE_X10 = 12'h44C;
	localparam logic [11:0] OV_OFF_STEP_X10 = 12'h064;
	localparam int OV_OFF_STEPS = 4;
	localparam logic [11:0] OV_MIN_X10 = 12'h3E8;
	localparam logic [11:0] OV_MAX_X10 = 12'h578;
	localparam logic [31:0] PCT_SCALE = 32'h3E8;
	localparam logic [15:0] REL_UNITY = 16'h0200;

	// Overvoltage response selector
	localparam logic [1:0] RESP_IGNORE = 2'h0;
	localparam logic [1:0] RESP_INVALID = 2'h3;

	typedef enum logic [1:0] {
		ST_INIT = 2'b00,
		ST_IDLE = 2'b01,
		ST_READ = 2'b10
	} cot_state_t;

	// Linear word to signed fixed point with frac fraction bits
	function automatic logic signed [31:0] lin_to_fix(input logic [15:0] w,
		input int frac, input logic rnd);
		logic signed [31:0] m;
		int sh;
		m = 32'(signed'(w[10:0]));
		sh = int'(signed'(w[EXP_MSB:EXP_LSB])) + frac;
		if (sh > 20) begin
			lin_to_fix = w[10] ? -FIX_SAT : FIX_SAT;
		end else if (sh >= 0) begin
			lin_to_fix = m <<< sh;
		end else if (sh < -20) begin
			lin_to_fix = '0;
		end else begin
			if (rnd)
				m = m + (32'sh1 <<< (-sh - 1));
			lin_to_fix = m >>> (-sh);
		end
	endfunction

	// Fixed point back to a linear word with a given exponent
	function automatic logic [15:0] fix_to_lin(input logic signed [31:0] v,
		input logic [4:0] e);
		logic signed [31:0] s;
		s = v;
		if (s > 32'sh3FF)
			s = 32'sh3FF;
		else if (s < -32'sh400)
			s = -32'sh400;
		fix_to_lin = {e, s[10:0]};
	endfunction

	// Limit within 100 to 140 percent of the reference
	function automatic logic ov_limit_valid(input logic [15:0] w,
		input logic [15:0] den);
		logic [31:0] num;
		num = 32'(w) * PCT_SCALE;
		ov_limit_valid = (num >= 32'(den) * 32'(OV_MIN_X10)) &&
			(num <= 32'(den) * 32'(OV_MAX_X10));
	endfunction

endpackage

/* File: core/cot_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cot_mem_if #(parameter int PHASES = 4);
	localparam int IW = (PHASES > 1) ? $clog2(PHASES) : 1;
	logic wr_en;
	logic wr_all;
	logic round_all;
	logic [IW-1:0] wr_idx;
	logic [15:0] wr_word;
	logic [IW-1:0] rd_idx;
	logic [15:0] rd_word;
	logic signed [31:0] sum_q;
	modport ctrl(output wr_en, wr_all, round_all, wr_idx, wr_word, rd_idx,
		input rd_word, sum_q);
	modport mem(input wr_en, wr_all, round_all, wr_idx, wr_word, rd_idx,
		output rd_word, sum_q);
endinterface
`default_nettype wire

/* File: core/cot_phase_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module cot_phase_mem #(
	parameter int PHASES = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Offset store access
	cot_mem_if.mem m
);
	if (PHASES < 1 || PHASES > cot_pkg::PHASES_MAX) begin : g_chk
		$error("cot_phase_mem: PHASES out of range");
	end

	logic [15:0] word [PHASES];
	logic [15:0] next_word [PHASES];
	logic [15:0] next_rd;
	logic signed [31:0] next_sum;

	// Per phase words; a stack write lands in every entry at once
	always_comb begin
		next_sum = '0;
		for (int i = 0; i < PHASES; i++) begin
			next_word[i] = word[i];
			if (m.round_all)
				next_word[i] = cot_pkg::fix_to_lin(
					cot_pkg::lin_to_fix(word[i], cot_pkg::OFS_FRAC, 1'b1),
					cot_pkg::OFS_EXP_RST);
			if (m.wr_all || (m.wr_en && int'(m.wr_idx) == i))
				next_word[i] = m.wr_word;
			// Stack offset is the sum of all phases
			next_sum = next_sum +
				cot_pkg::lin_to_fix(word[i], cot_pkg::OFS_FRAC, 1'b0);
		end
		next_rd = word[m.rd_idx];
	end

	// Read data and sum come out of registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < PHASES; i++)
				word[i] <= cot_pkg::OFS_RST;
			m.rd_word <= cot_pkg::OFS_RST;
			m.sum_q <= '0;
		end else begin
			word <= next_word;
			m.rd_word <= next_rd;
			m.sum_q <= next_sum;
		end
	end
endmodule
`default_nettype wire

/* File: core/cot_ov_step.sv */
`timescale 1ns/1ps
`default_nettype none
module cot_ov_step (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Setup
	input wire logic active,
	input wire logic converting,
	input wire logic fmt_abs,
	input wire logic [15:0] limit_word,
	input wire logic [15:0] vout_target,
	input wire logic [15:0] vout_sense,
	// Results
	output logic [11:0] ov_pct_x10,
	output logic [15:0] ov_threshold,
	output logic ov_fault
);
	logic [15:0] den;
	logic [31:0] num;
	logic [11:0] cand;
	logic [11:0] next_pct;
	logic [31:0] thr_full;
	logic [15:0] next_thr;
	logic next_fault;

	// Smallest hardware step at or above the programmed ratio
	always_comb begin
		den = fmt_abs ? vout_target : cot_pkg::REL_UNITY;
		num = 32'(limit_word) * cot_pkg::PCT_SCALE;
		next_pct = cot_pkg::OV_MAX_X10;
		cand = '0;
		if (converting) begin
			for (int k = cot_pkg::OV_RUN_STEPS - 1; k >= 0; k--) begin
				cand = cot_pkg::OV_RUN_BASE_X10 +
					12'(cot_pkg::OV_RUN_STEP_X10 * k);
				if (num <= 32'(den) * 32'(cand))
					next_pct = cand;
			end
		end else begin
			for (int k = cot_pkg::OV_OFF_STEPS - 1; k >= 0; k--) begin
				cand = cot_pkg::OV_OFF_BASE_X10 +
					12'(cot_pkg::OV_OFF_STEP_X10 * k);
				if (num <= 32'(den) * 32'(cand))
					next_pct = cand;
			end
		end
		// Threshold always follows the live target, never the stored word
		thr_full = 32'(vout_target) * 32'(ov_pct_x10) / cot_pkg::PCT_SCALE;
		next_thr = thr_full[15:0];
		next_fault = active &&
			(32'(vout_sense) * cot_pkg::PCT_SCALE >
			32'(vout_target) * 32'(ov_pct_x10));
	end

	// Step and compare are registered; one cycle of extra latency is fine
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ov_pct_x10 <= cot_pkg::OV_MAX_X10;
			ov_threshold <= '0;
			ov_fault <= 1'b0;
		end else begin
			ov_pct_x10 <= next_pct;
			ov_threshold <= next_thr;
			ov_fault <= next_fault;
		end
	end
endmodule
`default_nettype wire

/* File: core/cot_regs.sv */
// Function
// - Reported current scaled by gain trim, default one
// - Trims are 5-bit exponent, 11-bit mantissa words
// - Gain change rescales overcurrent fault and warning
// - Out of range writes flag status, alert host
// - Gain rounded to 1/64 after NVM, max 1.984
// - Each phase has offset; stack offset is sum
// - Fine offset writes accepted in range; NVM rounds
// - Pointer 00h-03h accesses one phase's offset
// - Pointer FFh write splits value across phases
// - Pointer FFh read returns phase zero times count
// - Overvoltage limit always relative to voltage target
// - Target change never rewrites stored limit word
// - Overvoltage detection live once the power-on load completes
// - Converting: round up, 105-140% in 2.5% steps
// - Not converting: 110-140% in 10% steps
// - Fault acts per overvoltage response configuration
// - Response 00 ignore, 01/10 shutdown, 11 invalid
`timescale 1ns/1ps
`default_nettype none
module cot_regs #(
	parameter int PHASES = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Command port
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic cmd_word,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic [7:0] phase_ptr,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	// Stack and output setup
	input wire logic [2:0] num_phases,
	input wire logic fmt_abs,
	input wire logic [15:0] vout_target,
	input wire logic converting,
	// Non-volatile backup
	input wire logic nvm_restore,
	input wire logic nvm_store,
	input wire logic [15:0] nvm_gain,
	input wire logic [15:0] nvm_offset,
	input wire logic [15:0] nvm_ov_limit,
	input wire logic [7:0] nvm_ov_resp,
	// Current telemetry
	input wire logic signed [15:0] sensed_current,
	input wire logic [15:0] oc_fault_base,
	input wire logic [15:0] oc_warn_base,
	output logic [15:0] reported_output_current,
	output logic [15:0] overcurrent_fault_threshold,
	output logic [15:0] overcurrent_warning_threshold,
	// Overvoltage
	input wire logic [15:0] vout_sense,
	output logic ov_fault,
	output logic ov_shutdown,
	output logic [2:0] ov_retry_limit,
	output logic [2:0] ov_delay,
	output logic [11:0] ov_pct_x10,
	output logic [15:0] ov_threshold,
	// Status
	input wire logic status_clear,
	output logic invalid_data,
	output logic invalid_cmd,
	output logic alert_n
);
	if (PHASES < 1 || PHASES > cot_pkg::PHASES_MAX) begin : g_chk
		$error("cot_regs: PHASES out of range");
	end

	localparam int IW = (PHASES > 1) ? $clog2(PHASES) : 1;
	cot_mem_if #(.PHASES(PHASES)) mif();

	cot_pkg::cot_state_t state, next_state;
	logic [15:0] current_gain_trim, next_gain;
	logic [15:0] overvoltage_fault_threshold, next_ov_limit;
	logic [7:0] overvoltage_response_config, next_ov_resp;
	logic [7:0] rd_code, next_rd_code;
	logic rd_all, next_rd_all;
	logic next_rsp_valid;
	logic [15:0] next_rsp_data;
	logic set_data, set_cmd;
	logic do_load, take, all_sel, phase_ok, word_reg;
	logic signed [31:0] wq, per_q, gain_q;
	logic [15:0] den;
	logic [15:0] next_rep, next_ocf, next_ocw;
	logic next_shut, next_inv_data, next_inv_cmd;
	logic hw_fault;

	// Offset split across the stack; divisor is a small constant per case
	function automatic logic signed [31:0] div_n(input logic signed [31:0] v,
		input logic [2:0] n);
		case (n)
			3'h2: div_n = v / 2;
			3'h3: div_n = v / 3;
			3'h4: div_n = v / 4;
			default: div_n = v;
		endcase
	endfunction

	// Nearest 1/64, clamped to 127/64, kept on the reset exponent
	function automatic logic [15:0] round_gain(input logic [15:0] w);
		logic signed [31:0] r;
		r = cot_pkg::lin_to_fix(w, cot_pkg::GAIN_NVM_FRAC, 1'b1);
		if (r > cot_pkg::GAIN_NVM_MAX)
			r = cot_pkg::GAIN_NVM_MAX;
		else if (r < 32'sh0)
			r = 32'sh0;
		r = r <<< cot_pkg::GAIN_NVM_SHIFT;
		round_gain = {cot_pkg::GAIN_EXP_RST, r[10:0]};
	endfunction

	// Gain must be positive and below two
	function automatic logic gain_ok(input logic [15:0] w);
		logic signed [31:0] q;
		q = cot_pkg::lin_to_fix(w, cot_pkg::GAIN_FRAC, 1'b0);
		gain_ok = (q > 32'sh0) && (q < cot_pkg::GAIN_LIMIT_Q);
	endfunction

	// Offset range check in the stored resolution
	function automatic logic ofs_ok(input logic signed [31:0] q);
		ofs_ok = (q >= cot_pkg::OFS_MIN_Q) && (q <= cot_pkg::OFS_MAX_Q);
	endfunction

	// Saturate to a signed 16-bit result
	function automatic logic [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sh7FFF)
			sat16 = 16'h7FFF;
		else if (v < -32'sh8000)
			sat16 = 16'h8000;
		else
			sat16 = v[15:0];
	endfunction

	// Command decode, NVM load and read answer
	always_comb begin
		next_state = state;
		next_gain = current_gain_trim;
		next_ov_limit = overvoltage_fault_threshold;
		next_ov_resp = overvoltage_response_config;
		next_rd_code = rd_code;
		next_rd_all = rd_all;
		next_rsp_valid = 1'b0;
		next_rsp_data = rsp_data;
		set_data = 1'b0;
		set_cmd = 1'b0;
		all_sel = (phase_ptr == cot_pkg::PHASE_ALL);
		phase_ok = all_sel || (phase_ptr < 8'(num_phases));
		word_reg = (cmd_code != cot_pkg::CMD_OV_RESP);
		den = fmt_abs ? vout_target : cot_pkg::REL_UNITY;
		wq = cot_pkg::lin_to_fix(cmd_wdata, cot_pkg::OFS_FRAC, 1'b0);
		per_q = all_sel ? div_n(wq, num_phases) : wq;
		mif.wr_en = 1'b0;
		mif.wr_all = 1'b0;
		mif.round_all = 1'b0;
		mif.wr_idx = phase_ptr[IW-1:0];
		mif.wr_word = cmd_wdata;
		mif.rd_idx = all_sel ? '0 : phase_ptr[IW-1:0];
		do_load = (state == cot_pkg::ST_INIT) ||
			(state == cot_pkg::ST_IDLE && nvm_restore);
		take = (state == cot_pkg::ST_IDLE) && !nvm_restore && !nvm_store &&
			cmd_valid;
		if (do_load) begin
			// Restore rounds to what the backup can hold
			next_gain = round_gain(nvm_gain);
			mif.wr_all = 1'b1;
			mif.wr_word = cot_pkg::fix_to_lin(
				cot_pkg::lin_to_fix(nvm_offset, cot_pkg::OFS_FRAC, 1'b1),
				cot_pkg::OFS_EXP_RST);
			next_ov_limit = nvm_ov_limit;
			if (nvm_ov_resp[7:6] != cot_pkg::RESP_INVALID)
				next_ov_resp = nvm_ov_resp;
			next_state = cot_pkg::ST_IDLE;
		end else if (state == cot_pkg::ST_IDLE && nvm_store) begin
			next_gain = round_gain(current_gain_trim);
			mif.round_all = 1'b1;
		end else if (take && (cmd_word != word_reg)) begin
			set_cmd = 1'b1;
		end else if (take && cmd_write) begin
			case (cmd_code)
				cot_pkg::CMD_GAIN: begin
					if (gain_ok(cmd_wdata))
						next_gain = cmd_wdata;
					else
						set_data = 1'b1;
				end
				cot_pkg::CMD_OFFSET: begin
					if (phase_ok && ofs_ok(per_q)) begin
						mif.wr_en = !all_sel;
						mif.wr_all = all_sel;
						if (all_sel)
							mif.wr_word = cot_pkg::fix_to_lin(per_q,
								cot_pkg::OFS_EXP_RST);
					end else begin
						set_data = 1'b1;
					end
				end
				cot_pkg::CMD_OV_LIMIT: begin
					if (cot_pkg::ov_limit_valid(cmd_wdata, den))
						next_ov_limit = cmd_wdata;
					else
						set_data = 1'b1;
				end
				cot_pkg::CMD_OV_RESP: begin
					if (cmd_wdata[7:6] == cot_pkg::RESP_INVALID)
						set_data = 1'b1;
					else
						next_ov_resp = cmd_wdata[7:0];
				end
				default: set_cmd = 1'b1;
			endcase
		end else if (take) begin
			case (cmd_code)
				cot_pkg::CMD_GAIN, cot_pkg::CMD_OV_LIMIT,
				cot_pkg::CMD_OV_RESP: begin
					next_rd_code = cmd_code;
					next_rd_all = 1'b0;
					next_state = cot_pkg::ST_READ;
				end
				cot_pkg::CMD_OFFSET: begin
					if (phase_ok) begin
						next_rd_code = cmd_code;
						next_rd_all = all_sel;
						next_state = cot_pkg::ST_READ;
					end else begin
						set_data = 1'b1;
					end
				end
				default: set_cmd = 1'b1;
			endcase
		end
		case (state)
			cot_pkg::ST_INIT, cot_pkg::ST_IDLE: begin
			end
			cot_pkg::ST_READ: begin
				next_rsp_valid = 1'b1;
				next_state = cot_pkg::ST_IDLE;
				case (rd_code)
					cot_pkg::CMD_GAIN: next_rsp_data = current_gain_trim;
					cot_pkg::CMD_OFFSET: begin
						if (rd_all)
							next_rsp_data = cot_pkg::fix_to_lin(32'(
								cot_pkg::lin_to_fix(mif.rd_word,
								cot_pkg::OFS_FRAC, 1'b0) *
								signed'({29'h0, num_phases})),
								cot_pkg::OFS_EXP_RST);
						else
							next_rsp_data = mif.rd_word;
					end
					cot_pkg::CMD_OV_LIMIT:
						next_rsp_data = overvoltage_fault_threshold;
					default:
						next_rsp_data = {8'h00, overvoltage_response_config};
				endcase
			end
			default: next_state = cot_pkg::ST_INIT;
		endcase
	end

	// Telemetry scaling, overvoltage action and sticky status
	always_comb begin
		gain_q = cot_pkg::lin_to_fix(current_gain_trim, cot_pkg::GAIN_FRAC,
			1'b0);
		next_rep = sat16(((32'(sensed_current) * gain_q) >>>
			cot_pkg::GAIN_FRAC) + mif.sum_q);
		next_ocf = sat16((signed'({16'h0000, oc_fault_base}) * gain_q) >>>
			cot_pkg::GAIN_FRAC);
		next_ocw = sat16((signed'({16'h0000, oc_warn_base}) * gain_q) >>>
			cot_pkg::GAIN_FRAC);
		next_shut = hw_fault && (overvoltage_response_config[7:6] !=
			cot_pkg::RESP_IGNORE);
		// A new event in the clearing cycle survives the clear
		next_inv_data = (invalid_data && !status_clear) || set_data;
		next_inv_cmd = (invalid_cmd && !status_clear) || set_cmd;
	end

	// State registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= cot_pkg::ST_INIT;
			current_gain_trim <= cot_pkg::GAIN_RST;
			overvoltage_fault_threshold <= cot_pkg::OV_LIMIT_RST;
			overvoltage_response_config <= cot_pkg::OV_RESP_RST;
			rd_code <= '0;
			rd_all <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
			reported_output_current <= '0;
			overcurrent_fault_threshold <= '0;
			overcurrent_warning_threshold <= '0;
			ov_shutdown <= 1'b0;
			invalid_data <= 1'b0;
			invalid_cmd <= 1'b0;
		end else begin
			state <= next_state;
			current_gain_trim <= next_gain;
			overvoltage_fault_threshold <= next_ov_limit;
			overvoltage_response_config <= next_ov_resp;
			rd_code <= next_rd_code;
			rd_all <= next_rd_all;
			rsp_valid <= next_rsp_valid;
			rsp_data <= next_rsp_data;
			reported_output_current <= next_rep;
			overcurrent_fault_threshold <= next_ocf;
			overcurrent_warning_threshold <= next_ocw;
			ov_shutdown <= next_shut;
			invalid_data <= next_inv_data;
			invalid_cmd <= next_inv_cmd;
		end
	end

	// Ready only when a command can be taken this cycle
	assign cmd_ready = (state == cot_pkg::ST_IDLE) && !nvm_restore &&
		!nvm_store;
	assign alert_n = !(invalid_data || invalid_cmd);
	assign ov_fault = hw_fault;
	assign ov_retry_limit = overvoltage_response_config[5:3];
	assign ov_delay = overvoltage_response_config[2:0];

	cot_phase_mem #(.PHASES(PHASES)) u_mem (
		.clk(clk),
		.nrst(nrst),
		.m(mif.mem)
	);

	// Detection runs from the first cycle after the power-on load
	cot_ov_step u_ov (
		.clk(clk),
		.nrst(nrst),
		.active(state != cot_pkg::ST_INIT),
		.converting(converting),
		.fmt_abs(fmt_abs),
		.limit_word(overvoltage_fault_threshold),
		.vout_target(vout_target),
		.vout_sense(vout_sense),
		.ov_pct_x10(ov_pct_x10),
		.ov_threshold(ov_threshold),
		.ov_fault(hw_fault)
	);
endmodule
`default_nettype wire

/* File: verification/cot_regs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module cot_regs_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Command port
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic cmd_word,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	// Setup and backup
	input wire logic converting,
	input wire logic nvm_restore,
	input wire logic nvm_store,
	// Overvoltage and status
	input wire logic ov_fault,
	input wire logic ov_shutdown,
	input wire logic [11:0] ov_pct_x10,
	input wire logic status_clear,
	input wire logic invalid_data,
	input wire logic invalid_cmd,
	input wire logic alert_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic take;
	logic take_rd;
	// Accepted command, split by direction
	assign take = cmd_valid && cmd_ready;
	assign take_rd = take && !cmd_write;
	sequence gain_read;
		take_rd && cmd_word && cmd_code == cot_pkg::CMD_GAIN;
	endsequence
	sequence answer;
		!rsp_valid ##1 rsp_valid;
	endsequence
	read_answer_a: assert property (gain_read |-> ##1 answer)
		else $error("read answer not two cycles after take");
	read_busy_a: assert property (gain_read |=> !cmd_ready)
		else $error("ready during read");
	rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
		else $error("answer longer than one cycle");
	rsp_cause_a: assert property (rsp_valid |-> $past(take_rd, 2))
		else $error("answer without read");
	width_err_a: assert property (take && !cmd_word &&
		cmd_code == cot_pkg::CMD_GAIN |=> invalid_cmd)
		else $error("byte gain access not flagged");
	resp_bad_a: assert property (take && cmd_write && !cmd_word &&
		cmd_code == cot_pkg::CMD_OV_RESP && cmd_wdata[7:6] == 2'b11
		|=> invalid_data)
		else $error("response 11 not flagged");
	flag_hold_a: assert property (invalid_data && !status_clear
		|=> invalid_data)
		else $error("flag dropped without clear");
	alert_tie_a: assert property (alert_n == !(invalid_data || invalid_cmd))
		else $error("alert does not follow flags");
	nvm_busy_a: assert property (nvm_restore || nvm_store |-> !cmd_ready)
		else $error("ready during backup access");
	step_span_a: assert property (ov_pct_x10 >= cot_pkg::OV_RUN_BASE_X10 &&
		ov_pct_x10 <= cot_pkg::OV_MAX_X10)
		else $error("step outside 105 to 140");
	off_steps_a: assert property (!converting [*3] |-> ov_pct_x10 inside
		{12'h44C, 12'h4B0, 12'h514, 12'h578})
		else $error("idle step not a 10 percent step");
	stop_cause_a: assert property ($rose(ov_shutdown) |-> $past(ov_fault))
		else $error("shutdown without fault");
endmodule
bind cot_regs cot_regs_checker chk (.clk, .nrst, .cmd_valid, .cmd_write,
	.cmd_word, .cmd_code, .cmd_wdata, .cmd_ready, .rsp_valid, .converting,
	.nvm_restore, .nvm_store, .ov_fault, .ov_shutdown, .ov_pct_x10,
	.status_clear, .invalid_data, .invalid_cmd, .alert_n);
`default_nettype wire

/* File: verification/cot_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cot_host_model (
	// Clock
	input wire logic clk,
	// Answers
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	// Requests
	output logic cmd_valid,
	output logic cmd_write,
	output logic cmd_word,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	output logic [7:0] phase_ptr
);
	int fails = 0;
	// Idle bus at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_word = 1'b1;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
		phase_ptr = 8'h00;
	end
	// One command held until taken; reads wait for the answer
	task automatic xfer(input logic wr, input logic word,
		input logic [7:0] code, input logic [7:0] ptr,
		input logic [15:0] wd, output logic [15:0] rd);
		int n;
		n = 0;
		rd = 16'h0000;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_word <= word;
		cmd_code <= code;
		cmd_wdata <= wd;
		phase_ptr <= ptr;
		do begin
			@(posedge clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 50);
		// Inverted leftovers so a stale value is never mistaken as valid
		cmd_valid <= 1'b0;
		cmd_wdata <= ~wd;
		cmd_code <= ~code;
		phase_ptr <= ~ptr;
		if (n >= 50)
			fails++;
		if (!wr) begin
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (rsp_valid !== 1'b1 && n < 8);
			rd = rsp_data;
			if (n >= 8)
				fails++;
		end
	endtask
endmodule
`default_nettype wire

/* File: verification/tb_cot_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_cot_regs;
	localparam logic [7:0] c_gain = cot_pkg::CMD_GAIN;
	localparam logic [7:0] c_ofs = cot_pkg::CMD_OFFSET;
	localparam logic [7:0] c_ov = cot_pkg::CMD_OV_LIMIT;
	localparam logic [7:0] c_resp = cot_pkg::CMD_OV_RESP;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic cmd_valid, cmd_write, cmd_word, cmd_ready, rsp_valid;
	logic [7:0] cmd_code, phase_ptr;
	logic [15:0] cmd_wdata, rsp_data;
	logic [2:0] num_phases = 3'h4;
	logic fmt_abs = 1'b1;
	logic converting = 1'b0;
	logic [15:0] vout_target = 16'h03E8;
	logic [15:0] vout_sense = 16'h03E8;
	logic nvm_restore = 1'b0;
	logic nvm_store = 1'b0;
	logic [15:0] nvm_gain = 16'hC880;
	logic [15:0] nvm_offset = 16'hE010;
	logic [15:0] nvm_ov_limit = 16'h04B0;
	logic [7:0] nvm_ov_resp = 8'h4A;
	logic signed [15:0] sensed_current = 16'sh0000;
	logic [15:0] oc_fault_base = 16'h0100;
	logic [15:0] oc_warn_base = 16'h0200;
	logic [15:0] reported_output_current, overcurrent_fault_threshold;
	logic [15:0] overcurrent_warning_threshold, ov_threshold;
	logic ov_fault, ov_shutdown, invalid_data, invalid_cmd, alert_n;
	logic [2:0] ov_retry_limit, ov_delay;
	logic [11:0] ov_pct_x10;
	logic status_clear = 1'b0;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [15:0] d;
	always #5 clk = ~clk;
	cot_host_model h (.clk, .cmd_ready, .rsp_valid, .rsp_data, .cmd_valid,
		.cmd_write, .cmd_word, .cmd_code, .cmd_wdata, .phase_ptr);
	cot_regs #(.PHASES(4)) dut (.clk, .nrst, .cmd_valid, .cmd_write,
		.cmd_word, .cmd_code, .cmd_wdata, .phase_ptr, .cmd_ready, .rsp_valid,
		.rsp_data, .num_phases, .fmt_abs, .vout_target, .converting,
		.nvm_restore, .nvm_store, .nvm_gain, .nvm_offset, .nvm_ov_limit,
		.nvm_ov_resp, .sensed_current, .oc_fault_base, .oc_warn_base,
		.reported_output_current, .overcurrent_fault_threshold,
		.overcurrent_warning_threshold, .vout_sense, .ov_fault, .ov_shutdown,
		.ov_retry_limit, .ov_delay, .ov_pct_x10, .ov_threshold,
		.status_clear, .invalid_data, .invalid_cmd, .alert_n);
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] code, input logic word,
		input logic [7:0] ptr, input logic [15:0] v);
		h.xfer(1'b1, word, code, ptr, v, d);
		@(posedge clk);
		#1;
	endtask
	task automatic rdc(input string name, input logic [7:0] code,
		input logic word, input logic [7:0] ptr, input logic [15:0] exp);
		h.xfer(1'b0, word, code, ptr, 16'h0000, d);
		chk(name, d, exp);
	endtask
	// Let registered outputs settle before looking
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic clr();
		@(posedge clk) status_clear <= 1'b1;
		@(posedge clk) status_clear <= 1'b0;
	endtask
	// Hang guard, well above the roughly 170 cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		rdc("gain", c_gain, 1'b1, 8'h00, 16'hC880);
		rdc("resp", c_resp, 1'b0, 8'h00, 16'h004A);
		chk("retry", ov_retry_limit, 16'h0001);
		chk("delay", ov_delay, 16'h0002);
		rdc("ofs p0", c_ofs, 1'b1, 8'h00, 16'hE010);
		wr(c_ofs, 1'b1, 8'h01, 16'hE020);
		rdc("ofs p1", c_ofs, 1'b1, 8'h01, 16'hE020);
		rdc("ofs p0 kept", c_ofs, 1'b1, 8'h00, 16'hE010);
		rdc("ofs all", c_ofs, 1'b1, 8'hFF, 16'hE040);
		wr(c_ofs, 1'b1, 8'hFF, 16'hE080);
		rdc("ofs p3", c_ofs, 1'b1, 8'h03, 16'hE020);
		rdc("ofs all 8A", c_ofs, 1'b1, 8'hFF, 16'hE080);
		@(posedge clk) sensed_current <= 16'sh00A0;
		settle();
		chk("current", reported_output_current, 16'h0120);
		wr(c_gain, 1'b1, 8'h00, 16'hC8C0);
		settle();
		chk("current x1.5", reported_output_current, 16'h0170);
		chk("oc fault", overcurrent_fault_threshold, 16'h0180);
		chk("oc warn", overcurrent_warning_threshold, 16'h0300);
		wr(c_gain, 1'b1, 8'h00, 16'hC900);
		chk("invalid gain", invalid_data, 16'h0001);
		chk("alert_n", alert_n, 16'h0000);
		rdc("gain kept", c_gain, 1'b1, 8'h00, 16'hC8C0);
		clr();
		wr(c_gain, 1'b0, 8'h00, 16'h0001);
		chk("byte gain", invalid_cmd, 16'h0001);
		clr();
		wr(c_gain, 1'b1, 8'h00, 16'hBBFC);
		settle();
		chk("oc fine", overcurrent_fault_threshold, 16'h01FE);
		@(posedge clk) nvm_store <= 1'b1;
		@(posedge clk) nvm_store <= 1'b0;
		settle();
		chk("oc stored", overcurrent_fault_threshold, 16'h01FC);
		chk("ov off 120", ov_pct_x10, 16'h04B0);
		@(posedge clk) converting <= 1'b1;
		settle();
		chk("ov run 120", ov_pct_x10, 16'h04B0);
		wr(c_ov, 1'b1, 8'h00, 16'h04BA);
		settle();
		chk("ov run 121", ov_pct_x10, 16'h04C9);
		@(posedge clk) converting <= 1'b0;
		settle();
		chk("ov off 121", ov_pct_x10, 16'h0514);
		@(posedge clk) vout_target <= 16'h044C;
		settle();
		rdc("ov kept", c_ov, 1'b1, 8'h00, 16'h04BA);
		chk("ov off 110", ov_pct_x10, 16'h044C);
		chk("ov thr", ov_threshold, 16'h04BA);
		@(posedge clk) vout_sense <= 16'h0514;
		settle();
		chk("ov fault", ov_fault, 16'h0001);
		chk("shutdown", ov_shutdown, 16'h0001);
		wr(c_resp, 1'b0, 8'h00, 16'h0000);
		settle();
		chk("ignore", ov_shutdown, 16'h0000);
		wr(c_resp, 1'b0, 8'h00, 16'h00C0);
		chk("resp 11", invalid_data, 16'h0001);
		clr();
		wr(c_ov, 1'b1, 8'h00, 16'h0640);
		chk("ov 145", invalid_data, 16'h0001);
		rdc("ov unchanged", c_ov, 1'b1, 8'h00, 16'h04BA);
		@(posedge clk) fmt_abs <= 1'b0;
		wr(c_ov, 1'b1, 8'h00, 16'h0270);
		settle();
		chk("ov rel", ov_pct_x10, 16'h0514);
		@(posedge clk) nvm_restore <= 1'b1;
		@(posedge clk) nvm_restore <= 1'b0;
		rdc("gain nvm", c_gain, 1'b1, 8'h00, 16'hC880);
		rdc("ofs nvm", c_ofs, 1'b1, 8'h02, 16'hE010);
		chk("host waits", 16'(h.fails), 16'h0000);
		give_verdict();
	end
endmodule
`default_nettype wire
